//--- ebawc_top.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// - width bit clear: 16-bit access
// - width bit set: 8-bit access
// - reset width: ones modes 1,3, else zeros
// - state bit clear: two-state bus cycle
// - state bit set: three states; reset ones
// - wait mode field selects mode; resets 00
// - wait count field 0..3; resets 11
// - wait enable clear: no wait control
module ebawc_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,           // system clock
   input  wire logic              rst_n,         // sync reset, active low
   input  wire logic [ADDR_W-1:0] s_awaddr,      // write address
   input  wire logic              s_awvalid,     // write address valid
   output logic                   s_awready,     // write address ready
   input  wire logic [31:0]       s_wdata,       // write data
   input  wire logic [3:0]        s_wstrb,       // write strobes
   input  wire logic              s_wvalid,      // write data valid
   output logic                   s_wready,      // write data ready
   output logic [1:0]             s_bresp,       // write response
   output logic                   s_bvalid,      // write response valid
   input  wire logic              s_bready,      // write response ready
   input  wire logic [ADDR_W-1:0] s_araddr,      // read address
   input  wire logic              s_arvalid,     // read address valid
   output logic                   s_arready,     // read address ready
   output logic [31:0]            s_rdata,       // read data
   output logic [1:0]             s_rresp,       // read response
   output logic                   s_rvalid,      // read data valid
   input  wire logic              s_rready,      // read data ready
   input  wire logic [2:0]        mode_pins,     // operating mode pins
   input  wire logic              wait_pin_n,    // external wait, low = wait
   input  wire logic              acc_start,     // cpu asks for a bus cycle
   input  wire logic [2:0]        acc_area,      // target area
   output logic                   acc_busy,      // bus cycle running
   output logic                   acc_done,      // bus cycle end pulse
   output logic                   acc_8bit       // latched width, 1 = 8-bit
);
   import ebawc_pkg::*;

   initial begin
      if (ADDR_W < 8 || ADDR_W > 32) $error("ebawc_top: ADDR_W must be 8..32");
   end

   // {hit, index}; index 0 width, 1 state, 2 wait, 3 wait enable
   function automatic logic [2:0] dec_addr(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] hi;
      hi = a >> 8;
      dec_addr = 3'h0;
      if (hi == '0) begin
         case (a[7:0])
            OFS_WIDTH: dec_addr = 3'h4;
            OFS_STATE: dec_addr = 3'h5;
            OFS_WAIT:  dec_addr = 3'h6;
            OFS_WCEN:  dec_addr = 3'h7;
            default:   dec_addr = 3'h0;
         endcase
      end
   endfunction

   logic [7:0]        width_reg;
   logic [7:0]        state_reg;
   logic [3:0]        wait_reg;
   logic [7:0]        wcen_reg;
   logic              init_done_reg;
   logic [2:0]        mode_s1_reg;
   logic [2:0]        mode_s2_reg;
   logic              wait_s1_reg;
   logic              wait_s2_reg;
   logic              aw_hold_reg;
   logic              w_hold_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [7:0]        wdata_reg;
   logic              wstrb0_reg;
   logic              t_busy;
   logic              t_done;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge clk) begin
      // mode pins run through reset so the init cycle sees settled levels
      mode_s1_reg <= mode_pins;
      mode_s2_reg <= mode_s1_reg;
      if (!rst_n) begin
         wait_s1_reg <= 1'b1;
         wait_s2_reg <= 1'b1;
      end else begin
         wait_s1_reg <= wait_pin_n;
         wait_s2_reg <= wait_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi write channel
   logic       aw_take;
   logic       w_take;
   logic       wr_commit;
   logic [2:0] wr_sel;
   assign aw_take   = s_awvalid && s_awready;
   assign w_take    = s_wvalid && s_wready;
   assign wr_commit = aw_hold_reg && w_hold_reg && !s_bvalid;
   assign wr_sel    = dec_addr(awaddr_reg);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= 8'h00;
         wstrb0_reg  <= 1'b0;
         s_awready   <= 1'b0;
         s_wready    <= 1'b0;
         s_bvalid    <= 1'b0;
         s_bresp     <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_awaddr;
         end
         if (w_take) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_wdata[7:0];
            wstrb0_reg <= s_wstrb[0];
         end
         s_awready <= !aw_take && !aw_hold_reg && !s_bvalid;
         s_wready  <= !w_take && !w_hold_reg && !s_bvalid;
         if (wr_commit) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            s_bvalid    <= 1'b1;
            s_bresp     <= wr_sel[2] ? RESP_OKAY : RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic wr_en;
   assign wr_en = wr_commit && wr_sel[2] && wstrb0_reg && init_done_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         width_reg     <= WIDTH_ALL_16;
         init_done_reg <= 1'b0;
      end else if (!init_done_reg) begin
         // mode pins sampled after release, once synchronised
         init_done_reg <= 1'b1;
         width_reg     <= (mode_s2_reg == MODE_1 || mode_s2_reg == MODE_3) ?
                          WIDTH_ALL_8 : WIDTH_ALL_16;
      end else if (wr_en && wr_sel[1:0] == 2'h0) begin
         width_reg <= wdata_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= RST_STATE;
         wait_reg  <= RST_WAIT[3:0];
         wcen_reg  <= RST_WCEN;
      end else if (wr_en) begin
         case (wr_sel[1:0])
            2'h1:    state_reg <= wdata_reg;
            2'h2:    wait_reg  <= wdata_reg[3:0] & WAIT_RW_MASK[3:0];
            2'h3:    wcen_reg  <= wdata_reg;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi read channel
   logic [2:0] rd_sel;
   logic [7:0] rd_val;
   assign rd_sel = dec_addr(s_araddr);

   always_comb begin
      case (rd_sel[1:0])
         2'h0:    rd_val = width_reg;
         2'h1:    rd_val = state_reg;
         2'h2:    rd_val = WAIT_RSV_ONES | {4'h0, wait_reg};
         default: rd_val = wcen_reg;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0;
         s_rresp   <= RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b1;
         s_rdata   <= rd_sel[2] ? {24'h0, rd_val} : 32'h0;
         s_rresp   <= rd_sel[2] ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid) begin
         if (s_rready) begin
            s_rvalid <= 1'b0;
         end
      end else begin
         s_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle setup
   ebawc_wmode_t wmode;
   logic [3:0]   wcount;
   logic         area_3st;
   logic         waits_on;
   logic         acc_go;
   logic [3:0]   base;
   logic [3:0]   cyc_total;
   logic         cyc_ext;

   assign wmode    = ebawc_wmode_t'(wait_reg[WMS_POS+:2]);
   assign wcount   = {2'h0, wait_reg[WC_POS+:2]};
   assign area_3st = state_reg[acc_area];
   assign waits_on = area_3st && wcen_reg[acc_area];
   assign acc_go   = acc_start && !t_busy && init_done_reg;
   assign base     = area_3st ? STATES_LONG : STATES_SHORT;

   always_comb begin
      cyc_total = base;
      cyc_ext   = 1'b0;
      case (wmode)
         WM_PROG: cyc_total = base + (waits_on ? wcount : 4'h0);
         WM_NONE: cyc_total = base;
         WM_PIN: begin
            cyc_total = base + (waits_on ? wcount : 4'h0);
            cyc_ext   = waits_on;
         end
         WM_AUTO: cyc_ext = waits_on;
         default: cyc_total = base;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_8bit <= 1'b0;
      end else if (acc_go) begin
         acc_8bit <= width_reg[acc_area];
      end
   end

   ebawc_cycle_timer u_timer (
      .clk     (clk),
      .rst_n   (rst_n),
      .start   (acc_go),
      .total   (cyc_total),
      .pin_ext (cyc_ext),
      .wait_ok (wait_s2_reg),
      .busy    (t_busy),
      .done    (t_done)
   );

   assign acc_busy = t_busy;
   assign acc_done = t_done;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_w16;
      @(posedge clk) disable iff (!rst_n)
      acc_go && !width_reg[acc_area] |=> !acc_8bit;
   endproperty
   a_w16: assert property (p_w16) else $error("16-bit area not latched");

   property p_w8;
      @(posedge clk) disable iff (!rst_n)
      acc_go && width_reg[acc_area] |=> acc_8bit;
   endproperty
   a_w8: assert property (p_w8) else $error("8-bit area not latched");

   property p_winit;
      @(posedge clk) disable iff (!rst_n)
      $rose(init_done_reg) |-> width_reg ==
         (($past(mode_s2_reg) == MODE_1 || $past(mode_s2_reg) == MODE_3) ?
          WIDTH_ALL_8 : WIDTH_ALL_16);
   endproperty
   a_winit: assert property (p_winit) else $error("width reset value wrong");

   property p_two;
      @(posedge clk) disable iff (!rst_n)
      acc_go && !area_3st |=> acc_busy [*2] ##1 (!acc_busy && acc_done);
   endproperty
   a_two: assert property (p_two) else $error("two-state cycle length wrong");

   property p_streset;
      @(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> state_reg == RST_STATE && wait_reg == RST_WAIT[3:0];
   endproperty
   a_streset: assert property (p_streset) else $error("reset values wrong");

   property p_nowait;
      @(posedge clk) disable iff (!rst_n)
      acc_go && area_3st && wmode == WM_NONE |=> acc_busy [*3] ##1 !acc_busy;
   endproperty
   a_nowait: assert property (p_nowait) else $error("no-wait mode inserted waits");

   property p_prog3;
      @(posedge clk) disable iff (!rst_n)
      acc_go && waits_on && wmode == WM_PROG && wcount == 4'h3
         |=> acc_busy [*6] ##1 !acc_busy;
   endproperty
   a_prog3: assert property (p_prog3) else $error("programmable wait count wrong");

   property p_wdis;
      @(posedge clk) disable iff (!rst_n)
      acc_go && area_3st && !wcen_reg[acc_area] |=> acc_busy [*3] ##1 acc_done;
   endproperty
   a_wdis: assert property (p_wdis) else $error("disabled area got waits");
endmodule

//--- ebawc_pkg.sv
package ebawc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_WIDTH     = 8'hEC;
   localparam logic [7:0] OFS_STATE     = 8'hF0;
   localparam logic [7:0] OFS_WAIT      = 8'hF4;
   localparam logic [7:0] OFS_WCEN      = 8'hF8;
   // reset values
   localparam logic [7:0] RST_STATE     = 8'hFF;
   localparam logic [7:0] RST_WAIT      = 8'hF3;
   localparam logic [7:0] RST_WCEN      = 8'hFF;
   localparam logic [7:0] WIDTH_ALL_8   = 8'hFF;
   localparam logic [7:0] WIDTH_ALL_16  = 8'h00;
   // wait control field layout
   localparam int         WMS_POS       = 2;
   localparam int         WC_POS        = 0;
   localparam logic [7:0] WAIT_RW_MASK  = 8'h0F;
   localparam logic [7:0] WAIT_RSV_ONES = 8'hF0;
   // bus cycle lengths in clock states
   localparam logic [3:0] STATES_SHORT  = 4'h2;
   localparam logic [3:0] STATES_LONG   = 4'h3;
   // operating modes decoded from mode pins
   localparam logic [2:0] MODE_1        = 3'h1;
   localparam logic [2:0] MODE_3        = 3'h3;
   // axi responses
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      WM_PROG = 2'h0,
      WM_NONE = 2'h1,
      WM_PIN  = 2'h2,
      WM_AUTO = 2'h3
   } ebawc_wmode_t;

   typedef enum logic [1:0] {
      TS_IDLE = 2'h1,
      TS_RUN  = 2'h2
   } ebawc_tstate_t;
endpackage

//--- ebawc_cycle_timer.sv
`timescale 1ns/10ps
module ebawc_cycle_timer (
   input  wire logic       clk,      // system clock
   input  wire logic       rst_n,    // sync reset, active low
   input  wire logic       start,    // begin a bus cycle
   input  wire logic [3:0] total,    // states incl. fixed waits
   input  wire logic       pin_ext,  // wait pin may stretch last state
   input  wire logic       wait_ok,  // synchronised wait pin, high = go
   output logic            busy,     // cycle in progress
   output logic            done      // one-cycle end pulse
);
   import ebawc_pkg::*;

   ebawc_tstate_t state_reg;
   logic [3:0]    cnt_reg;
   logic          ext_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= TS_IDLE;
         cnt_reg   <= 4'h0;
         ext_reg   <= 1'b0;
         busy      <= 1'b0;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_reg)
            TS_IDLE: begin
               if (start) begin
                  state_reg <= TS_RUN;
                  cnt_reg   <= total - 4'h1;
                  ext_reg   <= pin_ext;
                  busy      <= 1'b1;
               end
            end
            TS_RUN: begin
               // with ext_reg set, a low wait pin holds the final state
               if (cnt_reg == 4'h0 && (!ext_reg || wait_ok)) begin
                  state_reg <= TS_IDLE;
                  busy      <= 1'b0;
                  done      <= 1'b1;
               end else if (cnt_reg != 4'h0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= TS_IDLE;
               busy      <= 1'b0;
            end
         endcase
      end
   end
endmodule

//--- ebawc_mem_model.sv
`timescale 1ns/10ps
module ebawc_mem_model (
   input  wire logic       clk,        // system clock
   input  wire logic       rst_n,      // sync reset, active low
   input  wire logic       acc_busy,   // bus cycle in progress
   input  wire logic [3:0] stretch,    // cycles a slow device holds wait
   output logic            wait_pin_n  // wait request, low = wait
);
   logic       busy_d_reg;
   logic [3:0] cnt_reg;
   // slow device pulls wait low from the first busy state; idles high on its pull-up
   always_ff @(posedge clk) begin
      busy_d_reg <= acc_busy;
      if (!rst_n) begin
         cnt_reg <= 4'h0;
      end else if (acc_busy && !busy_d_reg) begin
         cnt_reg <= stretch;
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
   assign wait_pin_n = !((acc_busy && !busy_d_reg && stretch != 4'h0) || cnt_reg != 4'h0);
endmodule

//--- ebawc_top_bench.sv
`timescale 1ns/10ps
module ebawc_top_bench;
   import ebawc_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [2:0]  mode_pins = 3'h1, acc_area = 3'h0;
   logic        acc_start = 1'b0, acc_busy, acc_done, acc_8bit, wait_pin_n;
   logic [3:0]  stretch = 4'h0;
   int          err_total = 0;
   int          check_count = 0;

   always #2 clk = ~clk;

   ebawc_top i_dut (.clk(clk), .rst_n(rst_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
      .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
      .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .mode_pins(mode_pins),
      .wait_pin_n(wait_pin_n), .acc_start(acc_start), .acc_area(acc_area),
      .acc_busy(acc_busy), .acc_done(acc_done), .acc_8bit(acc_8bit));

   ebawc_mem_model i_mem (.clk(clk), .rst_n(rst_n), .acc_busy(acc_busy),
      .stretch(stretch), .wait_pin_n(wait_pin_n));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic hang(input string nm);
      err_total++;
      $display("CHECK FAILED %s expected answer seen none", nm);
      tally_and_finish();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
      if (n == 50) hang("bvalid");
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rready <= 1'b0;
      if (n == 50) hang("rvalid");
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      chk("rdata", {24'h0, d}, rdata);
   endtask

   // counts busy cycles up to the done pulse; width is judged in the first busy cycle
   task automatic acc_run(input logic [2:0] a, input logic exp8, output int len);
      int n;
      len = 0;
      @(posedge clk);
      acc_start <= 1'b1;
      acc_area <= a;
      @(posedge clk);
      acc_start <= 1'b0;
      for (n = 0; n < 50; n++) begin
         #1;
         if (acc_busy === 1'b1) len++;
         if (len == 1 && acc_busy === 1'b1) chk("acc_8bit", {31'h0, exp8}, {31'h0, acc_8bit});
         if (acc_done === 1'b1) break;
         @(posedge clk);
      end
      if (n == 50) hang("acc_done");
   endtask

   task automatic cfg(input logic [7:0] st, wt, we, wd);
      wr(OFS_STATE, st, RESP_OKAY);
      wr(OFS_WAIT, wt, RESP_OKAY);
      wr(OFS_WCEN, we, RESP_OKAY);
      wr(OFS_WIDTH, wd, RESP_OKAY);
   endtask

   task automatic cfg_acc(input logic [7:0] st, wt, we, wd, input logic [2:0] a,
                          input logic exp8, input int exp_len);
      int len;
      cfg(st, wt, we, wd);
      acc_run(a, exp8, len);
      chk("busy states", exp_len, len);
   endtask

   task automatic do_reset(input logic [2:0] m);
      @(posedge clk);
      rst_n <= 1'b0;
      mode_pins <= m;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      int m;
      for (m = 1; m <= 4; m++) begin
         do_reset(3'(m));
         rd(OFS_WIDTH, (m == 1 || m == 3) ? WIDTH_ALL_8 : WIDTH_ALL_16, RESP_OKAY);
      end
      rd(OFS_STATE, RST_STATE, RESP_OKAY);
      rd(OFS_WAIT, RST_WAIT, RESP_OKAY);
      rd(OFS_WCEN, RST_WCEN, RESP_OKAY);
      $display("reset test ended");
   endtask

   task automatic t_regs;
      wr(OFS_WIDTH, 8'h5A, RESP_OKAY);
      rd(OFS_WIDTH, 8'h5A, RESP_OKAY);
      wr(OFS_WAIT, 8'h00, RESP_OKAY);
      rd(OFS_WAIT, WAIT_RSV_ONES, RESP_OKAY);
      wr(8'hFC, 8'h00, RESP_SLVERR);
      rd(8'hFC, 8'h00, RESP_SLVERR);
      $display("register test ended");
   endtask

   task automatic t_access;
      cfg_acc(8'h00, 8'h06, 8'hFF, 8'h01, 3'h0, 1'b1, 2);
      cfg_acc(8'hFF, 8'h02, 8'hFF, 8'h01, 3'h1, 1'b0, 5);
      cfg_acc(8'hFF, 8'h06, 8'hFF, 8'h00, 3'h1, 1'b0, 3);
      cfg_acc(8'hFF, 8'h0B, 8'hFF, 8'h00, 3'h7, 1'b0, 6);
      cfg_acc(8'hFF, 8'h0F, 8'hFF, 8'h80, 3'h7, 1'b1, 3);
      cfg_acc(8'hFF, 8'h03, 8'hFB, 8'h00, 3'h2, 1'b0, 3);
      cfg_acc(8'hFE, 8'h03, 8'hFF, 8'h00, 3'h0, 1'b0, 2);
      cfg_acc(8'hFF, 8'h00, 8'hFF, 8'h00, 3'h3, 1'b0, 3);
      cfg_acc(8'hFF, 8'h01, 8'hFF, 8'h00, 3'h3, 1'b0, 4);
      $display("access test ended");
   endtask

   // a slow device holds wait low; only enabled three-state areas may stretch
   task automatic t_pinwait;
      int len;
      stretch <= 4'h8;
      cfg(8'hFF, 8'h0F, 8'hFF, 8'h00);
      acc_run(3'h1, 1'b0, len);
      chk("pin stretch", 32'h1, {31'h0, len > 3});
      cfg(8'hFF, 8'h0B, 8'hFF, 8'h00);
      acc_run(3'h1, 1'b0, len);
      chk("pin count stretch", 32'h1, {31'h0, len > 6});
      cfg_acc(8'hFF, 8'h0F, 8'hFD, 8'h00, 3'h1, 1'b0, 3);
      cfg_acc(8'hFD, 8'h0B, 8'hFF, 8'h00, 3'h1, 1'b0, 2);
      $display("pin wait test ended");
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_regs();
      t_access();
      t_pinwait();
      tally_and_finish();
   end
endmodule
